//--- verilog/ras_defs.vh
// Purpose: constants for the return address stack
// Assumes: classic wishbone, 8-bit data in low lane of a 32-bit word
// Notes:   offsets are byte addresses on the bus
`ifndef RAS_DEFS_VH
`define RAS_DEFS_VH
`define RAS_PTR_OFS      8'hDF
`define RAS_ENTRY_BASE   8'hF0
`define RAS_ENTRY_LAST   8'hFF
`define RAS_GIE_BIT      7
`define RAS_PTR_RST      3'h7
`define RAS_GIE_RST      1'h0
`define RAS_HI_RST       5'h00
`define RAS_LO_RST       8'h00
`define RAS_DEPTH        8
`define RAS_PC_W         13
`endif

//--- verilog/ras_ptr.v
// Purpose: stack pointer with push, pop and software load
// Assumes: push and pop never both high
// Notes:   wraps modulo eight, no error flag
`timescale 1ns/1ns
`include "ras_defs.vh"
module ras_ptr (
	// clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// controls
	input  wire       push_i,
	input  wire       pop_i,
	input  wire       load_i,
	input  wire [2:0] load_val_i,
	// state
	output reg  [2:0] ptr_o
);
	always @(posedge clk_i) begin
		if (rst_i) begin
			ptr_o <= `RAS_PTR_RST;
		end else if (push_i) begin
			ptr_o <= ptr_o - 3'h1;
		end else if (pop_i) begin
			ptr_o <= ptr_o + 3'h1;
		end else if (load_i) begin
			ptr_o <= load_val_i;
		end
	end
endmodule // ras_ptr

//--- verilog/ras_mem.v
// Purpose: eight entries of 13-bit saved program counter
// Assumes: one write port, two read indexes
// Notes:   flip-flop storage
`timescale 1ns/1ns
`include "ras_defs.vh"
module ras_mem (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// write port
	input  wire        we_i,
	input  wire [2:0]  widx_i,
	input  wire [12:0] wdat_i,
	// read ports
	input  wire [2:0]  ridx_i,
	output wire [12:0] rdat_o,
	input  wire [2:0]  sidx_i,
	output wire [12:0] sdat_o
);
	reg [12:0] ent_q [0:7];
	integer i;
	always @(posedge clk_i) begin
		if (rst_i) begin
			for (i = 0; i < `RAS_DEPTH; i = i + 1) begin
				ent_q[i] <= {`RAS_HI_RST, `RAS_LO_RST};
			end
		end else if (we_i) begin
			ent_q[widx_i] <= wdat_i;
		end
	end
	assign rdat_o = ent_q[ridx_i];
	assign sdat_o = ent_q[sidx_i];
endmodule // ras_mem

//--- verilog/ras_top.v
// Purpose: return address stack with wishbone register access
// Assumes: sequencer pulses push or pop one cycle; inputs synchronous
// Notes:   push wins over a bus write to the pointer or an entry in the same cycle
//
// Notes on behaviour
// - eight entries save the program counter on call and interrupt entry
// - three bit pointer sits in bits 2..0 of the pointer register
// - entry keeps pc 12..8 in high byte low bits, 7..0 in low byte
// - push decrements pointer, pop increments it
// - push happens on call instruction and interrupt entry
// - interrupt return and subroutine return both pop
// - pop returns the newest entry to the program counter
// - push writes entry indexed by inverted old pointer
// - ninth push wraps pointer to 110, overflow, entry lost
// - pointer at 0xDF, entry bytes at 0xF0 to 0xFF
// - bit 7 is global interrupt enable, resets 0; pointer resets 111
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns
`include "ras_defs.vh"
module ras_top (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// sequencer
	input  wire        call_i,
	input  wire        irq_entry_i,
	input  wire        subroutine_return_instr_i,
	input  wire        interrupt_return_instr_i,
	input  wire [12:0] pc_i,
	output reg  [12:0] ret_pc_o,
	output reg         ret_valid_o,
	output reg         global_irq_enable_o,
	output reg         stack_overflow_o
);
	//****************************************
	// stack control
	//****************************************
	wire        push = call_i | irq_entry_i;
	wire        pop  = ~push & (subroutine_return_instr_i | interrupt_return_instr_i);
	wire [2:0]  pointer_bits;
	wire [12:0] top_dat;
	wire [12:0] sw_dat;
	reg         gie_q;
	reg  [2:0]  cnt_q;
	wire [2:0]  ptr_up  = pointer_bits + 3'h1;

	// entry addressed by a pointer value; push and pop must agree on it
	function [2:0] ras_entry_of;
		input [2:0] ptr;
		begin
			ras_entry_of = ~ptr;
		end
	endfunction

	// bus decode
	wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wr      = req & wb_we_i & wb_sel_i[0];
	wire        hit_ptr = (wb_adr_i == `RAS_PTR_OFS);
	wire        hit_ent = (wb_adr_i >= `RAS_ENTRY_BASE);
	// entry pairs: even offset high byte, odd low byte, F0/F1 = entry 7
	wire [2:0]  sw_idx  = 3'h7 - wb_adr_i[3:1];
	wire        sw_lo   = wb_adr_i[0];
	wire        sw_we   = wr & hit_ent & ~push;
	wire [12:0] sw_wdat = sw_lo ? {sw_dat[12:8], wb_dat_i[7:0]}
	                            : {wb_dat_i[4:0], sw_dat[7:0]};

	ras_ptr u_ptr (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.push_i     (push),
		.pop_i      (pop),
		.load_i     (wr & hit_ptr),
		.load_val_i (wb_dat_i[2:0]),
		.ptr_o      (pointer_bits)
	);

	ras_mem u_mem (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.we_i   (push | sw_we),
		.widx_i (push ? ras_entry_of(pointer_bits) : sw_idx),
		.wdat_i (push ? pc_i : sw_wdat),
		.ridx_i (ras_entry_of(ptr_up)),
		.rdat_o (top_dat),
		.sidx_i (sw_idx),
		.sdat_o (sw_dat)
	);

	//****************************************
	// sequencer outputs
	//****************************************
	// overflow: count of occupied levels saturates at seven, pointer 111 then marks eight full; a ninth push loses data
	always @(posedge clk_i) begin
		if (rst_i) begin
			ret_pc_o         <= 13'h0000;
			ret_valid_o      <= 1'b0;
			stack_overflow_o <= 1'b0;
			cnt_q            <= 3'h0;
		end else begin
			ret_valid_o <= pop;
			if (pop) begin
				ret_pc_o <= top_dat;
			end
			// a push wins over a pointer write in the same cycle, so the flag set
			// by a ninth push is never lost to a clear the pointer did not take
			if (push) begin
				stack_overflow_o <= stack_overflow_o |
					((cnt_q == 3'h7) & (pointer_bits == 3'h7));
				if (cnt_q != 3'h7) begin
					cnt_q <= cnt_q + 3'h1;
				end
			end else if (pop) begin
				cnt_q <= (cnt_q == 3'h0) ? 3'h0 : cnt_q - 3'h1;
				stack_overflow_o <= 1'b0;
			end else if (wr & hit_ptr) begin
				cnt_q <= 3'h7 - wb_dat_i[2:0];
				stack_overflow_o <= 1'b0;
			end
		end
	end

	//****************************************
	// interrupt enable
	//****************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			gie_q               <= `RAS_GIE_RST;
			global_irq_enable_o <= `RAS_GIE_RST;
		end else begin
			if (wr & hit_ptr) begin
				gie_q <= wb_dat_i[`RAS_GIE_BIT];
			end
			global_irq_enable_o <= (wr & hit_ptr) ? wb_dat_i[`RAS_GIE_BIT] : gie_q;
		end
	end

	//****************************************
	// bus answer
	//****************************************
	// every address answers in one cycle; unmapped reads return zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (req & ~wb_we_i) begin
				if (hit_ptr) begin
					wb_dat_o <= {24'h00_0000, gie_q, 4'h0, pointer_bits};
				end else if (hit_ent & sw_lo) begin
					wb_dat_o <= {24'h00_0000, sw_dat[7:0]};
				end else if (hit_ent) begin
					wb_dat_o <= {24'h00_0000, 3'h0, sw_dat[12:8]};
				end else begin
					wb_dat_o <= 32'h0000_0000;
				end
			end
		end
	end
endmodule // ras_top

//--- testbench/ras_seq.sv
// Purpose: request model of the core sequencer
// Assumes: go is high one cycle per request
// Notes: a held go would push or pop every cycle
`timescale 1ns/1ns
module ras_seq (
	input  wire       go_i,
	input  wire [1:0] op_i,
	output wire [3:0] rq_o
);
	// one hot: call, irq entry, return, irq return
	assign rq_o = go_i ? 4'h1 << op_i : 4'h0;
endmodule // ras_seq

//--- testbench/ras_top_monitor.sv
// Purpose: port checks of ras_top
// Assumes: one clock, sync reset
// Notes: bound below
`timescale 1ns/1ns
module ras_mon (
	input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ret_valid_o,
	input wire call_i, irq_entry_i, subroutine_return_instr_i, interrupt_return_instr_i,
	input wire global_irq_enable_o, stack_overflow_o,
	input wire [3:0] wb_sel_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i, wb_dat_o,
	input wire [12:0] pc_i, ret_pc_o
);
	wire pu = call_i | irq_entry_i;
	wire po = subroutine_return_instr_i | interrupt_return_instr_i;
	wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_next: assert property (tk |=> wb_ack_o) else $error("ack");
	a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
	a_rd_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("dat");
	a_gie_wr: assert property (tk && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'hDF |=>
		global_irq_enable_o == $past(wb_dat_i[7])) else $error("gie");
	a_pop_rv: assert property (po && !pu |=> ret_valid_o) else $error("rv");
	a_rv_pulse: assert property (!po |=> !ret_valid_o) else $error("rv");
	a_lifo_pair: assert property (pu ##1 (po && !pu) |=> ret_pc_o == $past(pc_i, 2))
		else $error("lifo");
	a_ovf_clr: assert property (po && !pu |=> !stack_overflow_o) else $error("ovf");
	c_pair: cover property (pu ##1 po);
	c_ovf: cover property ($rose(stack_overflow_o));
	c_wr: cover property (tk && wb_we_i);
endmodule // ras_mon
bind ras_top ras_mon u_mon (.*);

//--- testbench/tb_top.sv
// Purpose: self checking bench of ras_top
// Assumes: ack one cycle after take
// Notes: software and sequencer requests start here
`timescale 1ns/1ns
module tb_top;
	reg clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_we_i = 1'b0, go = 1'b0;
	reg [7:0] wb_adr_i = 8'h00;
	reg [31:0] wb_dat_i = 32'h0000_0000;
	reg [1:0] op = 2'h0;
	reg [12:0] pc_i = 13'h0000;
	wire wb_stb_i = wb_cyc_i;
	reg [3:0] wb_sel_i = 4'h1, sel_v = 4'h1;
	wire [3:0] rq;
	wire call_i = rq[0], irq_entry_i = rq[1];
	wire subroutine_return_instr_i = rq[2], interrupt_return_instr_i = rq[3];
	wire [31:0] wb_dat_o;
	wire [12:0] ret_pc_o;
	wire wb_ack_o, ret_valid_o, global_irq_enable_o, stack_overflow_o;
	integer n_errors = 0, checks = 0, k;
	always #2 clk_i = ~clk_i;
	ras_seq seq (.go_i(go), .op_i(op), .rq_o(rq));
	ras_top dut (.*);
	function [12:0] pv(input integer i);
		pv = 13'h1234 + 13'(i) * 13'h0111;
	endfunction
	task complete_run;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task chk(input [39:0] n, input [31:0] s, e);
		checks++;
		if (s !== e) n_errors++;
		if (s !== e) $display("[ERR] %0s exp %h got %h", n, e, s);
	endtask
	// read data is taken at the ack edge, before the slave's own update lands
	task wb(input w, input [7:0] a, d, input [31:0] e);
		integer i;
		@(posedge clk_i) {wb_cyc_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <=
			{1'b1, w, sel_v, a, 24'h00_0000, d};
		for (i = 0; i < 50 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
		chk("ack", i < 50, 1);
		if (i == 50) complete_run;
		if (!w) chk("read", wb_dat_o, e);
		wb_cyc_i <= 1'b0;
	endtask
	task req(input [1:0] o, input [12:0] p);
		@(posedge clk_i) {go, op, pc_i} <= {1'b1, o, p};
		@(posedge clk_i) go <= 1'b0;
		#1;
	endtask
	task t_regs;
		wb(1'b0, 8'hDF, 8'h00, 32'h0000_0007);
		wb(1'b1, 8'hDF, 8'h87, 0);
		chk("gie", global_irq_enable_o, 1);
		// a write without lane 0 selected must leave the register alone
		sel_v = 4'h0;
		wb(1'b1, 8'hDF, 8'h00, 0);
		sel_v = 4'h1;
		wb(1'b0, 8'hDF, 8'h00, 32'h0000_0087);
		wb(1'b1, 8'hF0, 8'hFF, 0);
		wb(1'b0, 8'hF0, 8'h00, 32'h0000_001F);
		wb(1'b0, 8'h10, 8'h00, 32'h0000_0000);
		wb(1'b1, 8'hDF, 8'h07, 0);
	endtask
	task t_lifo;
		for (k = 0; k < 8; k++) req({1'b0, k[0]}, pv(k));
		wb(1'b0, 8'hDF, 8'h00, 32'h0000_0007);
		wb(1'b0, 8'hFF, 8'h00, 32'h0000_0034);
		for (k = 7; k >= 0; k--) begin
			req({1'b1, k[0]}, 13'h0000);
			chk("pop", ret_pc_o, pv(k));
			chk("valid", ret_valid_o, 1);
		end
		@(posedge clk_i) {go, op, pc_i} <= {1'b1, 2'h0, pv(9)};
		req(2'h2, 13'h0000);
		chk("pair", ret_pc_o, pv(9));
	endtask
	task t_wrap;
		req(2'h3, 13'h0000);
		chk("empty", ret_pc_o, pv(7));
		wb(1'b0, 8'hDF, 8'h00, 32'h0000_0000);
		wb(1'b1, 8'hDF, 8'h07, 0);
		for (k = 0; k < 9; k++) req(2'h1, pv(k));
		wb(1'b0, 8'hDF, 8'h00, 32'h0000_0006);
		chk("ovf", stack_overflow_o, 1);
		req(2'h2, 13'h0000);
		chk("wrap", ret_pc_o, pv(8));
		chk("ovclr", stack_overflow_o, 0);
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_lifo;
		t_wrap;
		complete_run;
	end
endmodule // tb_top
